// File: pkg/serial_config_pkg.sv
// Constants and carrier types for the serial configuration write port
package serial_config_pkg;
    localparam int unsigned WORD_W        = 24;
    localparam int unsigned SEL_W         = 4;
    localparam int unsigned NUM_REGS      = 16;
    localparam logic [3:0]  LOCK_TRIG_IDX = 4'h0;
    localparam logic [3:0]  PWR_REG_IDX   = 4'h1;
    localparam int unsigned PWR_LSB       = 4;
    localparam int unsigned PWR_W         = 4;
    localparam logic [23:0] WORD_RESET    = 24'h000000;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [NUM_REGS-1:0][WORD_W-1:0] reg_bank_t;

    // Pins of the serial port seen on the system clock
    typedef struct packed {
        logic latch_load_strobe;
        logic chip_enable;
    } pin_sync_t;

    // Outputs of the port, all registered
    typedef struct packed {
        reg_bank_t        regs;
        logic [PWR_W-1:0] section_pwr;
        logic             relock_pending;
        logic             lock_trigger_pulse;
    } cfg_out_t;
endpackage

// File: logic/serial_config_write_port.sv
// Three-wire serial configuration write port with register bank and power control
//
// Overview of operation
// - Words arrive MSB first; first bit ends on top
// - Trailing bits shifted in select the target register
// - Data sampled on every rising serial clock edge
// - Strobe rising copies shift register into selected register
// - Chip enable high powers sections requested by bits
// - Writes accepted while chip enable holds part down
`timescale 1ns/1ps
module serial_config_write_port
    import serial_config_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     arst_n,
    input  wire logic     sclk,
    input  wire logic     sdata,
    input  wire logic     latch_load_strobe,
    input  wire logic     chip_enable,
    output cfg_out_t      cfg
);

    // Serial clock domain: only the shift register lives here. It runs on the
    // host's own clock so no bit is lost to synchroniser delay; the price is
    // that the word crosses to the system clock without a handshake of its own.
    typedef struct packed {
        word_t shreg;
    } link_state_t;

    // System clock domain. The strobe and chip enable each pass two flops
    // (s1, s2) before any logic reads them; prev holds the last s2 value so
    // rising edges are found without reading the possibly metastable stage.
    typedef struct packed {
        pin_sync_t s1;
        pin_sync_t s2;
        pin_sync_t prev;
        cfg_out_t  out;
    } core_state_t;

    link_state_t link_d, link_q;
    core_state_t core_d, core_q;

    logic                  le_rise;
    logic                  ce_rise;
    logic                  lock_write;
    logic [SEL_W-1:0]      sel;

    // Each rising serial clock pushes one bit in at the bottom; older bits move
    // toward the top, so after a full word the first bit sent sits on top
    always_comb begin
        link_d       = link_q;
        link_d.shreg = {link_q.shreg[WORD_W-2:0], sdata};
    end

    // The serial clock idles low, so releasing reset here cannot create an edge
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // The host keeps the serial clock still around the strobe, so the shift
    // register is quiet when the synchronised strobe edge samples it.
    // Limitation: a host that clocks new bits while the strobe is high, or
    // within three system clocks of its rise, can store a torn word.
    assign le_rise = core_q.s2.latch_load_strobe && !core_q.prev.latch_load_strobe;
    assign ce_rise = core_q.s2.chip_enable && !core_q.prev.chip_enable;
    assign sel     = link_q.shreg[SEL_W-1:0];
    // Lock register write, shared by the relock and pulse checks
    assign lock_write = le_rise && (sel == LOCK_TRIG_IDX);

    always_comb begin
        core_d                        = core_q;
        core_d.s1.latch_load_strobe   = latch_load_strobe;
        core_d.s1.chip_enable         = chip_enable;
        core_d.s2                     = core_q.s1;
        core_d.prev                   = core_q.s2;
        // The pulse lasts one cycle: cleared here unless a lock write sets it
        core_d.out.lock_trigger_pulse = 1'b0;
        // Chip enable does not gate the write path
        if (le_rise) begin
            core_d.out.regs[sel] = link_q.shreg;
            if (sel == LOCK_TRIG_IDX) begin
                core_d.out.lock_trigger_pulse = 1'b1;
                core_d.out.relock_pending     = 1'b0;
            end
        end
        // A power-up landing with a lock write still leaves relock pending:
        // losing the power-up would let the host skip the relock it owes
        if (ce_rise) begin
            core_d.out.relock_pending = 1'b1;
        end
        // Power bits are read from the bank every cycle while enabled, so a power word written
        // while enabled reaches the sections one cycle after it is stored
        if (core_q.s2.chip_enable) begin
            core_d.out.section_pwr = core_q.out.regs[PWR_REG_IDX][PWR_LSB +: PWR_W];
        end else begin
            core_d.out.section_pwr = '0;
        end
    end

    // The bank has its own reset constant; every other state bit clears to zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_q          <= '0;
            core_q.out.regs <= {NUM_REGS{WORD_RESET}};
        end else begin
            core_q <= core_d;
        end
    end

    // Every output is a flop of core_q; nothing combinational reaches the pins
    assign cfg = core_q.out;

    // Link domain checks, clocked by the serial clock itself
    AST_MSB_FIRST: assert property (@(posedge sclk) disable iff (!arst_n)
        ##1 link_q.shreg[WORD_W-1:1] == $past(link_q.shreg[WORD_W-2:0]))
        else $error("Shift register did not move toward the top bit");

    AST_SAMPLE_RISE: assert property (@(posedge sclk) disable iff (!arst_n)
        ##1 link_q.shreg[0] == $past(sdata))
        else $error("Serial data not sampled on rising serial clock");

    // Write path checks on the system clock
    AST_SELECT_TARGET: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise |=> core_q.out.regs[$past(sel)] == $past(link_q.shreg))
        else $error("Word not stored in register named by select bits");

    AST_LATCH_ON_RISE: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(latch_load_strobe) ##1 latch_load_strobe [*2] ##1 1'b1
        |-> $past(le_rise))
        else $error("Strobe rise did not produce a latch within three cycles");

    // Power control, write hold and lock pulse checks
    AST_POWER_UP: assert property (@(posedge clk) disable iff (!arst_n)
        core_q.s2.chip_enable |=>
        core_q.out.section_pwr == $past(core_q.out.regs[PWR_REG_IDX][PWR_LSB +: PWR_W]))
        else $error("Sections not powered per power control bits");

    AST_POWER_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
        !core_q.s2.chip_enable |=> core_q.out.section_pwr == '0)
        else $error("Sections powered while chip enable low");

    AST_WRITE_WHILE_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise && !core_q.s2.chip_enable |=>
        core_q.out.regs[$past(sel)] == $past(link_q.shreg))
        else $error("Write lost while powered down");

    AST_HOLD_NO_STROBE: assert property (@(posedge clk) disable iff (!arst_n)
        !le_rise |=> $stable(core_q.out.regs))
        else $error("Register changed without strobe rise");

    AST_LOCK_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise && sel == LOCK_TRIG_IDX |=> core_q.out.lock_trigger_pulse ##1
        !core_q.out.lock_trigger_pulse)
        else $error("Lock trigger pulse not one cycle");

    // Crossing checks: the word is taken without a handshake, so it must be still
    AST_SHREG_STILL: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise |-> $stable(link_q.shreg))
        else $error("Shift register moved while its word was being stored");

    AST_NO_STROBE_NO_LATCH: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise |-> $past(latch_load_strobe, 2))
        else $error("Word stored with no strobe on the pin");

    AST_CE_RISE_SEEN: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(chip_enable) |-> ##2 ce_rise)
        else $error("Chip enable rise not seen after two synchroniser stages");

    // Registers not named by the select bits keep their words
    for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_keep
        AST_UNSELECTED_KEPT: assert property (@(posedge clk) disable iff (!arst_n)
            le_rise && (sel != SEL_W'(gi)) |=> $stable(core_q.out.regs[gi]))
            else $error("Register not named by the select bits was overwritten");
    end

    // A new power word must reach the sections while the part stays enabled;
    // the word is taken from the shift register two cycles back
    AST_PWR_NEW_WORD: assert property (@(posedge clk) disable iff (!arst_n)
        le_rise && sel == PWR_REG_IDX && core_q.s2.chip_enable ##1 core_q.s2.chip_enable
        |=> core_q.out.section_pwr == $past(link_q.shreg[PWR_LSB +: PWR_W], 2))
        else $error("New power word not applied while enabled");

    AST_CE_FALL_SEEN: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(chip_enable) |-> ##3 core_q.out.section_pwr == '0)
        else $error("Sections still powered three cycles after chip enable fell");

    AST_RELOCK_SET: assert property (@(posedge clk) disable iff (!arst_n)
        ce_rise |=> core_q.out.relock_pending)
        else $error("Power up did not flag a pending relock");

    AST_RELOCK_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        lock_write && !ce_rise |=> !core_q.out.relock_pending)
        else $error("Lock trigger write did not clear pending relock");

    AST_RELOCK_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        !lock_write && !ce_rise |=> $stable(core_q.out.relock_pending))
        else $error("Pending relock changed with no power up or lock write");

    AST_PULSE_ONLY_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
        !lock_write |=> !core_q.out.lock_trigger_pulse)
        else $error("Lock trigger pulse without a lock register write");

    // Only looks while reset is held, so it carries no disable clause
    AST_RESET_QUIET: assert property (@(posedge clk)
        !arst_n |-> core_q.out.section_pwr == '0 && !core_q.out.relock_pending
        && !core_q.out.lock_trigger_pulse)
        else $error("Outputs not cleared while reset held");

    // Main scenarios that the bench is expected to reach
    COV_LOCK_WRITE: cover property (@(posedge clk) disable iff (!arst_n)
        le_rise && sel == LOCK_TRIG_IDX);
    COV_DOWN_WRITE: cover property (@(posedge clk) disable iff (!arst_n)
        le_rise && !core_q.s2.chip_enable);
    COV_POWER_UP: cover property (@(posedge clk) disable iff (!arst_n)
        ce_rise ##[1:1000] core_q.out.lock_trigger_pulse);
    COV_PWR_WORD_LIVE: cover property (@(posedge clk) disable iff (!arst_n)
        le_rise && sel == PWR_REG_IDX && core_q.s2.chip_enable);
    COV_POWER_DOWN: cover property (@(posedge clk) disable iff (!arst_n)
        $fell(core_q.s2.chip_enable) ##1 core_q.out.section_pwr == '0);

endmodule

// File: bench/cfg_host.sv
// Behavioural host that shifts configuration words into the serial port
`timescale 1ns/1ps
module cfg_host
    import serial_config_pkg::*;
(
    output logic sclk,
    output logic sdata,
    output logic latch_load_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        latch_load_strobe = 1'b0;
    end
    // Odd offset keeps link edges away from system clock edges
    task automatic send(input word_t w, input int extra, input bit latch);
        #1.3;
        for (int i = WORD_W + extra - 1; i >= 0; i--) begin
            sdata = (i < WORD_W) ? w[i] : ~w[i % WORD_W];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        // Clock stands still; stale data is inverted so it cannot pass as valid
        sdata = ~sdata;
        #40 latch_load_strobe = latch;
        #120 latch_load_strobe = 1'b0;
        #40;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the serial configuration write port
`timescale 1ns/1ps
module tb
    import serial_config_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        chip_enable;
    logic        sclk;
    logic        sdata;
    logic        strobe;
    cfg_out_t    cfg;
    reg_bank_t   prev_q;
    word_t       exp_q[$];
    word_t       w;
    word_t       m;
    logic [31:0] seed;
    int          bad_count = 0;
    int          tests_run = 0;
    serial_config_write_port u_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .sdata(sdata),
        .latch_load_strobe(strobe), .chip_enable(chip_enable), .cfg(cfg));
    cfg_host u_host (.sclk(sclk), .sdata(sdata), .latch_load_strobe(strobe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input word_t got, input word_t exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Any change of the bank must be the oldest pending write, landing at its select
    always @(posedge clk) begin
        prev_q <= cfg.regs;
        if (arst_n && cfg.regs !== prev_q) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, cfg.regs, prev_q);
            end else begin
                m = exp_q.pop_front();
                check(cfg.regs[m[3:0]], m);
                check(word_t'(cfg.lock_trigger_pulse), word_t'(m[3:0] == LOCK_TRIG_IDX));
            end
        end
    end
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
    initial begin
        arst_n = 1'b0;
        chip_enable = 1'b0;
        seed = 32'h00000041;
        repeat (12) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        // Leading junk bits must be pushed out the top
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            w = {seed[23:4], 4'(i % NUM_REGS)};
            exp_q.push_back(w);
            u_host.send(w, i % 3, 1'b1);
        end
        seed = xs(seed);
        u_host.send(seed[23:0], 0, 1'b0);
        $display("test bank writes done");
        w = {seed[23:8], 4'ha, PWR_REG_IDX};
        exp_q.push_back(w);
        u_host.send(w, 0, 1'b1);
        check(word_t'(cfg.section_pwr), '0);
        @(negedge clk) chip_enable = 1'b1;
        repeat (5) @(negedge clk);
        check(word_t'(cfg.section_pwr), word_t'(w[7:4]));
        check(word_t'(cfg.relock_pending), 24'h000001);
        w = {seed[23:4], LOCK_TRIG_IDX};
        exp_q.push_back(w);
        u_host.send(w, 0, 1'b1);
        check(word_t'(cfg.relock_pending), 24'h000000);
        w = {seed[23:8], 4'h5, PWR_REG_IDX};
        exp_q.push_back(w);
        u_host.send(w, 1, 1'b1);
        check(word_t'(cfg.section_pwr), word_t'(w[PWR_LSB +: PWR_W]));
        @(negedge clk) chip_enable = 1'b0;
        repeat (5) @(negedge clk);
        check(word_t'(cfg.section_pwr), '0);
        check(word_t'(cfg.relock_pending), 24'h000000);
        check(word_t'(exp_q.size()), '0);
        $display("test power control done");
        final_report();
    end
endmodule
